// ---- verilog/axis_fault_pkg.sv ----
package axis_fault_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned SYNC_WAIT_MS  = 200;
	localparam int unsigned FLASH_HALF_MS = 250;
	localparam int unsigned SYNC_WAIT_CYC = SYNC_WAIT_MS * (CLK_HZ / 1000);
	localparam int unsigned FLASH_CYC     = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam logic [1:0]  BOOT_LAST     = 2'h2;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG    = 8'h00;
	localparam logic [7:0] OFS_HOST_CTRL = 8'h04;
	localparam logic [7:0] OFS_COMMAND   = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0c;
	localparam logic [7:0] OFS_DEMAND    = 8'h10;
	localparam logic [7:0] OFS_JOG_SPEED = 8'h14;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CFG_SENSOR_MONITOR_SETTING_LSB = 0;
	localparam int CFG_POL      = 2;
	localparam int CFG_RC       = 3;
	localparam int CFG_SYNC     = 4;
	localparam int CFG_PRS_MA   = 5;
	localparam int CFG_POS_MA   = 6;
	localparam int CFG_SSI      = 7;
	localparam int HC_ENABLE    = 0;
	localparam int HC_JOG_POS   = 1;
	localparam int HC_JOG_NEG   = 2;
	localparam int HC_PQ        = 3;
	localparam int CMD_SAVE     = 0;
	localparam int CMD_CLEAR    = 1;
	localparam int ST_READY     = 6;
	localparam int ST_ACTIVE    = 7;

	localparam logic [1:0]  SENSOR_MONITOR_SETTING_OFF      = 2'h0;
	localparam logic [1:0]  SENSOR_MONITOR_SETTING_ON       = 2'h1;
	localparam logic [1:0]  SENSOR_MONITOR_SETTING_AUTO     = 2'h2;
	localparam logic [7:0]  CONFIG_RST    = 8'he1;
	localparam logic [3:0]  HOST_CTRL_RST = 4'h0;
	localparam logic [15:0] DEMAND_RST    = 16'h0000;
	localparam logic [15:0] JOG_SPEED_RST = 16'h1000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic pressure_control_active_bit;
		logic jog_pos;
		logic jog_neg;
		logic sync_start;
		logic hw_activation;
		logic host_link;
		logic prs_fb_bad;
		logic pos_fb_bad;
		logic ssi_bad;
	} pin_in_type;

	typedef struct packed {
		logic enable;
		logic pressure_control_active_bit;
		logic jog_pos;
		logic jog_neg;
	} ctrl_type;

	typedef struct packed {
		logic sync;
		logic link;
		logic param;
		logic ssi;
		logic pos;
		logic prs;
	} fault_type;

	typedef enum logic [1:0] {
		SYNC_IDLE = 2'b00,
		SYNC_WAIT = 2'b01,
		SYNC_RUN  = 2'b11
	} sync_state_type;

endpackage

// ---- verilog/axis_fault_supervisor.sv ----
`timescale 1ns/1ns
// Behaviour
// - Faults are supervised only while monitoring is ON or AUTO.
// - Pressure feedback faults trip only with pressure control active.
// - Broken 4-20 mA feedback or bad serial sensor switches the output off.
// - A power-up parameter error blocks the output until a new save.
// - Saving after a parameter error clears it and reloads the defaults.
// - Losing the host tool link in remote control mode switches off.
// - Sync mode trips if activation input stays low 200 ms after start.
// - A detected fault makes the ready indicator flash instead of glow.
// - The jog inputs drive the valve output to move the axis at the jog speed.
// - A polarity setting inverts the sign of the valve output.
// - In remote control mode only the host tool's requests are obeyed.
module axis_fault_supervisor
	import axis_fault_pkg::*;
#(
	parameter int unsigned SYNC_WAIT_CYCLES = SYNC_WAIT_CYC,
	parameter int unsigned FLASH_CYCLES     = FLASH_CYC
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic        [7:0]  adr_i,
	input  wire logic        [31:0] dat_i,
	output logic             [31:0] dat_o,
	input  wire logic               we_i,
	input  wire logic        [3:0]  sel_i,
	input  wire logic               stb_i,
	input  wire logic               cyc_i,
	output logic                    ack_o,
	input  wire pin_in_type         pins_i,
	input  wire logic               param_error_i,
	output logic signed      [15:0] valve_o,
	output logic                    valve_active_o,
	output logic                    ready_o,
	output logic                    ready_led_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pin_in_type     pins_meta_q;
	pin_in_type     pins_q;
	logic           perr_meta_q;
	logic           perr_q;
	logic           start_prev_q;
	logic [1:0]     boot_cnt_q;
	logic           boot_done_q;
	logic [7:0]     cfg_q;
	logic [3:0]     host_q;
	logic [15:0]    demand_q;
	logic [15:0]    jog_speed_q;
	fault_type      fault_q;
	fault_type      fault_hit;
	fault_type      fault_d;
	sync_state_type sync_q;
	sync_state_type sync_d;
	logic [31:0]    wait_cnt_q;
	logic [31:0]    flash_cnt_q;
	logic           flash_q;
	logic           ack_q;
	logic [31:0]    rdata_q;
	logic signed [15:0] valve_q;
	logic           active_q;
	logic           ready_q;
	logic           led_q;

	wire logic [1:0]  sensor_monitor_setting        = cfg_q[CFG_SENSOR_MONITOR_SETTING_LSB +: 2];
	wire logic        output_polarity_setting         = cfg_q[CFG_POL];
	wire logic        rc_mode     = cfg_q[CFG_RC];
	wire logic        sync_mode   = cfg_q[CFG_SYNC];
	wire logic        wb_fire     = cyc_i & stb_i & ~ack_q;
	wire logic        wb_wr       = wb_fire & we_i;
	wire logic        wr_cfg      = wb_wr & sel_i[0] & (adr_i == OFS_CONFIG);
	wire logic        wr_host     = wb_wr & sel_i[0] & (adr_i == OFS_HOST_CTRL);
	wire logic        wr_cmd      = wb_wr & sel_i[0] & (adr_i == OFS_COMMAND);
	wire logic        wr_demand   = wb_wr & (adr_i == OFS_DEMAND);
	wire logic        wr_jog      = wb_wr & (adr_i == OFS_JOG_SPEED);
	wire logic        save_wr     = wr_cmd & dat_i[CMD_SAVE];
	wire logic        clear_wr    = wr_cmd & dat_i[CMD_CLEAR];
	wire logic        reload      = save_wr & fault_q.param;
	wire logic        capture     = ~boot_done_q & (boot_cnt_q == BOOT_LAST);
	wire logic        mon_on      = (sensor_monitor_setting == SENSOR_MONITOR_SETTING_ON) | (sensor_monitor_setting == SENSOR_MONITOR_SETTING_AUTO);
	wire logic        start_rise  = pins_q.sync_start & ~start_prev_q;
	wire logic [31:0] sync_last   = 32'(SYNC_WAIT_CYCLES - 1);
	wire logic [31:0] flash_last  = 32'(FLASH_CYCLES - 1);
	wire logic        wait_expire = (wait_cnt_q == sync_last);
	wire logic        flash_tick  = (flash_cnt_q == flash_last);
	wire logic        any_fault   = |fault_q;
	wire ctrl_type    pin_ctrl    = '{pins_q.enable, pins_q.pressure_control_active_bit,
	                                  pins_q.jog_pos, pins_q.jog_neg};
	wire ctrl_type    host_ctrl   = '{host_q[HC_ENABLE], host_q[HC_PQ],
	                                  host_q[HC_JOG_POS], host_q[HC_JOG_NEG]};
	wire ctrl_type    ctrl        = rc_mode ? host_ctrl : pin_ctrl;
	wire logic        ready_d     = ctrl.enable & ~any_fault
	                              & boot_done_q;
	wire logic        jog_p       = ctrl.jog_pos & ~ctrl.jog_neg;
	wire logic        jog_n       = ctrl.jog_neg & ~ctrl.jog_pos;
	wire logic signed [15:0] raw  = jog_p ? jog_speed_q :
	                                jog_n ? -jog_speed_q : demand_q;
	wire logic signed [15:0] pol_out = output_polarity_setting ? -raw : raw;
	wire logic signed [15:0] valve_d = ready_d ? pol_out : DEMAND_RST;
	wire logic        led_d       = any_fault ? flash_q : ready_d;
	wire logic [7:0]  status      = {active_q, ready_q, fault_q};
	wire logic [31:0] rdata_d     =
		(adr_i == OFS_CONFIG)    ? {24'h000000, cfg_q} :
		(adr_i == OFS_HOST_CTRL) ? {28'h0000000, host_q} :
		(adr_i == OFS_STATUS)    ? {24'h000000, status} :
		(adr_i == OFS_DEMAND)    ? {16'h0000, demand_q} :
		(adr_i == OFS_JOG_SPEED) ? {16'h0000, jog_speed_q} : 32'h00000000;

	// ----------------------------------------------------------------
	// Input synchronisers and power-up capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		pins_meta_q <= pins_i;
		pins_q      <= pins_meta_q;
		perr_meta_q <= param_error_i;
		perr_q      <= perr_meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_prev_q <= 1'b0;
			boot_cnt_q   <= 2'h0;
			boot_done_q  <= 1'b0;
		end else begin
			start_prev_q <= pins_q.sync_start;
			boot_cnt_q   <= boot_done_q ? boot_cnt_q : boot_cnt_q + 2'h1;
			boot_done_q  <= boot_done_q | capture;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= wb_fire;
			rdata_q <= wb_fire ? rdata_d : rdata_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i | reload) begin
			cfg_q       <= CONFIG_RST;
			host_q      <= HOST_CTRL_RST;
			demand_q    <= DEMAND_RST;
			jog_speed_q <= JOG_SPEED_RST;
		end else begin
			if (wr_cfg)
				cfg_q <= dat_i[7:0];
			if (wr_host)
				host_q <= dat_i[3:0];
			if (wr_demand & sel_i[0])
				demand_q[7:0] <= dat_i[7:0];
			if (wr_demand & sel_i[1])
				demand_q[15:8] <= dat_i[15:8];
			if (wr_jog & sel_i[0])
				jog_speed_q[7:0] <= dat_i[7:0];
			if (wr_jog & sel_i[1])
				jog_speed_q[15:8] <= dat_i[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Fault detection
	// ----------------------------------------------------------------
	assign fault_hit.prs   = mon_on & cfg_q[CFG_PRS_MA]
	                       & pins_q.prs_fb_bad & ctrl.pressure_control_active_bit;
	assign fault_hit.pos   = mon_on & cfg_q[CFG_POS_MA] & pins_q.pos_fb_bad;
	assign fault_hit.ssi   = mon_on & cfg_q[CFG_SSI] & pins_q.ssi_bad;
	assign fault_hit.param = mon_on & capture & perr_q;
	assign fault_hit.link  = mon_on & rc_mode & ~pins_q.host_link;
	assign fault_hit.sync  = mon_on & (sync_q == SYNC_WAIT)
	                       & wait_expire & ~pins_q.hw_activation;

	assign fault_d.prs   = (fault_q.prs & ~clear_wr) | fault_hit.prs;
	assign fault_d.pos   = (fault_q.pos & ~clear_wr) | fault_hit.pos;
	assign fault_d.ssi   = (fault_q.ssi & ~clear_wr) | fault_hit.ssi;
	assign fault_d.param = (fault_q.param & ~save_wr) | fault_hit.param;
	assign fault_d.link  = (fault_q.link & ~clear_wr) | fault_hit.link;
	assign fault_d.sync  = (fault_q.sync & ~clear_wr) | fault_hit.sync;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			fault_q <= '0;
		else
			fault_q <= fault_d;
	end

	// ----------------------------------------------------------------
	// Synchronisation start supervision
	// ----------------------------------------------------------------
	always_comb begin
		sync_d = sync_q;
		unique case (sync_q)
			SYNC_IDLE: begin
				if (sync_mode & start_rise)
					sync_d = SYNC_WAIT;
			end
			SYNC_WAIT: begin
				if (~sync_mode)
					sync_d = SYNC_IDLE;
				else if (pins_q.hw_activation)
					sync_d = SYNC_RUN;
				else if (wait_expire)
					sync_d = SYNC_IDLE;
			end
			SYNC_RUN: begin
				if (~sync_mode | ~pins_q.sync_start)
					sync_d = SYNC_IDLE;
			end
			default: begin
				sync_d = SYNC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_q     <= SYNC_IDLE;
			wait_cnt_q <= 32'h00000000;
		end else begin
			sync_q     <= sync_d;
			wait_cnt_q <= (sync_q == SYNC_WAIT) ? wait_cnt_q + 32'h1
			                                    : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Flash divider and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_cnt_q <= 32'h00000000;
			flash_q     <= 1'b0;
		end else begin
			flash_cnt_q <= flash_tick ? 32'h00000000 : flash_cnt_q + 32'h1;
			flash_q     <= flash_q ^ flash_tick;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valve_q  <= DEMAND_RST;
			active_q <= 1'b0;
			ready_q  <= 1'b0;
			led_q    <= 1'b0;
		end else begin
			valve_q  <= valve_d;
			active_q <= ready_d;
			ready_q  <= ready_d;
			led_q    <= led_d;
		end
	end

	assign dat_o          = rdata_q;
	assign ack_o          = ack_q;
	assign valve_o        = valve_q;
	assign valve_active_o = active_q;
	assign ready_o        = ready_q;
	assign ready_led_o    = led_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence sync_armed_s;
		mon_on && sync_q == SYNC_WAIT && !pins_q.hw_activation;
	endsequence

	sequence sync_expired_s;
		sync_armed_s ##0 wait_expire;
	endsequence

	sequence output_off_s;
		!ready_o && !valve_active_o;
	endsequence

	monitor_off_a: assert property (
		!mon_on && !fault_q.pos |=> !fault_q.pos)
		else $error("position fault set while monitoring off");
	pressure_gate_a: assert property (
		!ctrl.pressure_control_active_bit && !fault_q.prs |=> !fault_q.prs)
		else $error("pressure fault set without pressure control");
	pressure_trip_a: assert property (
		mon_on && cfg_q[CFG_PRS_MA] && pins_q.prs_fb_bad && ctrl.pressure_control_active_bit
		|=> fault_q.prs ##1 output_off_s)
		else $error("pressure feedback fault not tripping output");
	feedback_trip_a: assert property (
		mon_on && cfg_q[CFG_POS_MA] && pins_q.pos_fb_bad
		|=> fault_q.pos ##1 !ready_o)
		else $error("position feedback fault not tripping output");
	serial_trip_a: assert property (
		mon_on && cfg_q[CFG_SSI] && pins_q.ssi_bad
		|=> fault_q.ssi ##1 output_off_s)
		else $error("serial sensor fault not tripping output");
	param_hold_a: assert property (
		fault_q.param && !save_wr |=> fault_q.param)
		else $error("parameter error cleared without save");
	boot_gate_a: assert property (!boot_done_q |=> !ready_o)
		else $error("output active before parameter check");
	save_reload_a: assert property (
		reload && !capture |=> !fault_q.param && cfg_q == CONFIG_RST)
		else $error("save did not clear error and reload defaults");
	link_loss_a: assert property (
		mon_on && rc_mode && !pins_q.host_link |=> fault_q.link ##1 !valve_active_o)
		else $error("host link loss did not switch off output");
	sync_arm_a: assert property (
		sync_q == SYNC_IDLE && sync_mode && start_rise |=> sync_q == SYNC_WAIT)
		else $error("sync start did not arm activation wait");
	sync_timeout_a: assert property (sync_expired_s |=> fault_q.sync)
		else $error("sync activation timeout not flagged");
	led_flash_a: assert property (
		any_fault |=> ready_led_o == $past(flash_q))
		else $error("ready indicator not flashing on fault");
	led_steady_a: assert property (
		!any_fault |=> ready_led_o == $past(ready_d))
		else $error("ready indicator not steady without fault");
	jog_drive_a: assert property (
		ready_d && jog_p && !output_polarity_setting |=> valve_o == $past(jog_speed_q))
		else $error("positive jog not driving valve output");
	negative_jog_a: assert property (
		ready_d && jog_n && !output_polarity_setting |=> valve_o == -$past(jog_speed_q))
		else $error("negative jog not driving valve output");
	polarity_flip_a: assert property (
		ready_d && output_polarity_setting |=> valve_o == -$past(raw))
		else $error("polarity setting not inverting output");
	remote_only_a: assert property (
		rc_mode && !host_q[HC_ENABLE] |=> !ready_o)
		else $error("machine controller enable obeyed in remote mode");
	ready_drop_a: assert property (
		any_fault |=> !ready_o && !valve_active_o)
		else $error("ready still high while a fault is latched");
	valve_idle_a: assert property (
		!ready_d |=> valve_o == DEMAND_RST && !valve_active_o)
		else $error("valve output driven while not ready");

endmodule

// ---- test/machine_ctrl_model.sv ----
`timescale 1ns/1ns
module machine_ctrl_model
	import axis_fault_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire pin_in_type req_i,
	input  wire logic       sync_mode_i,
	input  wire logic       ready_i,
	output pin_in_type      pins_o
);
	// ----------------------------------------------------------------
	// Stop of the synchronised system on lost ready
	// ----------------------------------------------------------------
	logic stop_q;
	logic ready_q;
	wire  logic lost_ready = sync_mode_i & ready_q & ~ready_i;

	always_ff @(posedge clk_i) begin
		ready_q <= rst_i ? 1'b0 : ready_i;
		if (rst_i | ~req_i.enable) begin
			stop_q <= 1'b0;
		end else if (lost_ready) begin
			stop_q <= 1'b1;
		end
	end

	always_comb begin
		pins_o        = req_i;
		pins_o.enable = req_i.enable & ~stop_q & ~lost_ready;
	end
endmodule

// ---- test/axis_fault_supervisor_test.sv ----
`timescale 1ns/1ns
module axis_fault_supervisor_test;
	import axis_fault_pkg::*;
	logic               clk_i;
	logic               rst_i;
	logic        [7:0]  adr;
	logic        [31:0] wdat;
	logic        [31:0] rdat;
	logic               we;
	logic        [3:0]  sel;
	logic               stb;
	logic               cyc;
	logic               ack;
	pin_in_type         req;
	pin_in_type         pins;
	logic               perr;
	logic               sync_mode;
	logic signed [15:0] valve;
	logic               active;
	logic               ready;
	logic               led;
	logic        [31:0] q;
	int                 err_count;
	int                 n_tests;
	logic        [2:0]  vin [5] = '{3'h0, 3'h4, 3'h3, 3'h1, 3'h6};
	logic        [15:0] vexp [5] = '{16'h1234, 16'h1000, 16'h1000,
		16'hedcc, 16'h1234};

	axis_fault_supervisor #(
		.SYNC_WAIT_CYCLES(50),
		.FLASH_CYCLES(8)
	) i_axis_fault_supervisor (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
		.dat_o(rdat), .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc),
		.ack_o(ack), .pins_i(pins), .param_error_i(perr),
		.valve_o(valve), .valve_active_o(active), .ready_o(ready),
		.ready_led_o(led)
	);

	machine_ctrl_model i_machine_ctrl_model (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.sync_mode_i(sync_mode), .ready_i(ready), .pins_o(pins)
	);

	// ----------------------------------------------------------------
	// Clock, tasks and report
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task chkb(input string s, input logic e, input logic g);
		chk(s, {31'h0, e}, {31'h0, g});
	endtask

	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'hf;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task st(input logic [7:0] e);
		wb(OFS_STATUS, 1'b0, 32'h0);
		chk("status", {24'h0, e}, q);
	endtask

	task led_chk(input logic flash);
		int ones;
		ones = 0;
		repeat (32) begin
			@(posedge clk_i);
			ones += (led === 1'b1);
		end
		chkb("led", 1'b1, flash ? (ones > 4 && ones < 28) : ones == 32);
	endtask

	task fcase(input logic [7:0] c, input logic pq, input int s,
		input logic hit);
		wb(OFS_CONFIG, 1'b1, {24'h0, c});
		req.pressure_control_active_bit <= pq;
		tick(8);
		chkb("ready_before", 1'b1, ready);
		req.prs_fb_bad <= (s == 0);
		req.pos_fb_bad <= (s == 1);
		req.ssi_bad    <= (s == 2);
		tick(8);
		chkb("ready", ~hit, ready);
		chkb("active", ~hit, active);
		st(hit ? 8'h01 << s : 8'hc0);
		led_chk(hit);
		req.prs_fb_bad <= 1'b0;
		req.pos_fb_bad <= 1'b0;
		req.ssi_bad    <= 1'b0;
		tick(3);
		wb(OFS_COMMAND, 1'b1, 32'h2);
		tick(8);
		chkb("ready_after", 1'b1, ready);
	endtask

	task done(input string s);
		$display("test %s done", s);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		tick(20000);
		err_count++;
		final_report;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{rst_i, perr, cyc, stb, we, adr, wdat, sel} = '0;
		rst_i = 1'b1;
		perr = 1'b1;
		sync_mode = 1'b0;
		err_count = 0;
		n_tests = 0;
		req = '0;
		req.enable = 1'b1;
		req.host_link = 1'b1;
		tick(3);
		rst_i <= 1'b0;
		tick(10);
		chkb("ready_perr", 1'b0, ready);
		st(8'h08);
		led_chk(1'b1);
		wb(OFS_CONFIG, 1'b0, 32'h0);
		chk("config_rst", 32'he1, q);
		wb(OFS_JOG_SPEED, 1'b0, 32'h0);
		chk("jog_rst", 32'h1000, q);
		wb(8'h1c, 1'b0, 32'h0);
		chk("unmapped", 32'h0, q);
		wb(OFS_CONFIG, 1'b1, 32'h61);
		wb(OFS_COMMAND, 1'b1, 32'h2);
		tick(8);
		chkb("ready_clear", 1'b0, ready);
		wb(OFS_COMMAND, 1'b1, 32'h1);
		perr <= 1'b0;
		wb(OFS_CONFIG, 1'b0, 32'h0);
		chk("config_saved", 32'he1, q);
		st(8'hc0);
		led_chk(1'b0);
		done("param");
		wb(OFS_DEMAND, 1'b1, 32'h1234);
		for (int i = 0; i < 5; i++) begin
			req.jog_pos <= vin[i][2];
			req.jog_neg <= vin[i][1];
			wb(OFS_CONFIG, 1'b1, {24'h0, 5'h1c, vin[i][0], 2'h1});
			tick(8);
			chk("valve", {16'h0, vexp[i]}, {16'h0, valve});
		end
		req.jog_pos <= 1'b0;
		req.jog_neg <= 1'b0;
		done("valve");
		fcase(8'he0, 1'b0, 1, 1'b0);
		fcase(8'he1, 1'b0, 1, 1'b1);
		fcase(8'he2, 1'b0, 1, 1'b1);
		fcase(8'he3, 1'b0, 1, 1'b0);
		fcase(8'he1, 1'b0, 0, 1'b0);
		fcase(8'he1, 1'b1, 0, 1'b1);
		fcase(8'he1, 1'b0, 2, 1'b1);
		done("faults");
		wb(OFS_CONFIG, 1'b1, 32'he9);
		tick(8);
		chkb("ready_rc_pin", 1'b0, ready);
		wb(OFS_HOST_CTRL, 1'b1, 32'h1);
		wb(OFS_HOST_CTRL, 1'b0, 32'h0);
		chk("host_ctrl", 32'h1, q);
		req.enable <= 1'b0;
		tick(8);
		chkb("ready_rc_host", 1'b1, ready);
		req.host_link <= 1'b0;
		tick(8);
		chkb("ready_link", 1'b0, ready);
		st(8'h10);
		req.host_link <= 1'b1;
		req.enable <= 1'b1;
		wb(OFS_HOST_CTRL, 1'b1, 32'h0);
		wb(OFS_CONFIG, 1'b1, 32'he1);
		wb(OFS_COMMAND, 1'b1, 32'h2);
		done("remote");
		sync_mode <= 1'b1;
		wb(OFS_CONFIG, 1'b1, 32'hf1);
		req.sync_start <= 1'b1;
		tick(30);
		chkb("ready_sync_wait", 1'b1, ready);
		tick(40);
		chkb("ready_sync_late", 1'b0, ready);
		chkb("ctrl_enable", 1'b0, pins.enable);
		st(8'h20);
		rst_i <= 1'b1;
		sync_mode <= 1'b0;
		req.sync_start <= 1'b0;
		tick(3);
		rst_i <= 1'b0;
		tick(3);
		chkb("ready_boot", 1'b0, ready);
		sync_mode <= 1'b1;
		wb(OFS_CONFIG, 1'b1, 32'hf1);
		req.sync_start <= 1'b1;
		req.hw_activation <= 1'b1;
		tick(80);
		chkb("ready_sync_ok", 1'b1, ready);
		st(8'hc0);
		done("sync");
		final_report;
	end
endmodule
